// ===== logic/nand_target_pkg.sv
// constants, states and carriers for the target command state machine
package nand_target_pkg;

  // ----------------------------------------------------------------
  // command and address codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_SYNC_RESET = 8'hFC;
  localparam logic [7:0] CMD_LUN_RESET = 8'hFA;
  localparam logic [7:0] CMD_READ_ID = 8'h90;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] ADDR_ID_CODE = 8'h00;
  localparam logic [7:0] ADDR_SIGNATURE = 8'h20;
  localparam logic [7:0] LAST_CMD_RESET = 8'hFF;

  // ----------------------------------------------------------------
  // register map, byte offsets on the bus
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_LAST_CMD = 8'h04;
  localparam logic [7:0] REG_CONFIG = 8'h08;
  localparam logic [7:0] REG_ID_BYTES = 8'h0C;
  localparam logic [7:0] REG_SIGNATURE = 8'h10;
  localparam int STAT_RB_BIT = 16;
  localparam int STAT_STATUS_OUT_BIT = 17;
  localparam int STAT_CHG_COL_BIT = 18;
  localparam int STAT_CHG_COL_ENH_BIT = 19;
  localparam int ID_DEV_LSB = 8;
  localparam int STATUS_BYTE_RDY_BIT = 6;
  localparam int STATUS_BYTE_ARDY_BIT = 5;
  localparam logic [2:0] CFG_ADDR_CYC_RESET = 3'h3;
  localparam logic [31:0] SIGNATURE_RESET = 32'h0000_0000;

  // ----------------------------------------------------------------
  // sizes and timing
  // ----------------------------------------------------------------
  localparam int MAX_LUNS = 8;
  localparam int LUN_SEL_W = 3;
  localparam int WAIT_W = 4;
  localparam logic [1:0] SIG_LAST_IDX = 2'h3;
  localparam int CLK_PERIOD_NS = 50;
  localparam int TGT_RST_NS = 200;
  localparam int TGT_RST_CYCLES_INT =
    (TGT_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [WAIT_W-1:0] TGT_RST_CYCLES =
    WAIT_W'(TGT_RST_CYCLES_INT);

  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  typedef enum logic [15:0] {
    ST_IDLE = 16'h0001,
    ST_IDLE_RD = 16'h0002,
    ST_IDLE_RD_STATUS = 16'h0004,
    ST_RS_EXEC = 16'h0008,
    ST_RST_SYNC = 16'h0010,
    ST_RST_LUN_EXEC = 16'h0020,
    ST_RST_LUN_ADDR = 16'h0040,
    ST_RST_LUN_PERFORM = 16'h0080,
    ST_RST_PERFORM = 16'h0100,
    ST_RST_END = 16'h0200,
    ST_RID_EXEC = 16'h0400,
    ST_RID_ADDR_ID = 16'h0800,
    ST_RID_MFR = 16'h1000,
    ST_RID_DEV = 16'h2000,
    ST_RID_ADDR_SIG = 16'h4000,
    ST_RID_SIG = 16'h8000
  } state_t;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic cmd;
    logic addr;
    logic rd;
    logic [7:0] io;
  } pins_t;

  typedef struct packed {
    pins_t pinMeta;
    pins_t pinSync;
    pins_t pinPrev;
    state_t state;
    state_t resumeState;
    logic [7:0] lastCommandCode;
    logic statusOutputFlag;
    logic columnChangeAllowed;
    logic enhancedColumnChangeAllowed;
    logic readyBusy;
    logic [2:0] addrCnt;
    logic [LUN_SEL_W-1:0] lunSel;
    logic [WAIT_W-1:0] waitCnt;
    logic [1:0] sigIdx;
    logic [7:0] ioOut;
    logic ioOe;
    logic [MAX_LUNS-1:0] lunReq;
    logic lunInval;
    logic wrPend;
    logic [7:0] wrAddr;
    logic [31:0] hrdata;
    logic hreadyout;
    logic [2:0] addrCycles;
    logic [7:0] mfrId;
    logic [7:0] devId;
    logic [31:0] sigWord;
  } core_t;

endpackage

// ===== logic/nand_target_reset_readid_fsm.sv
// target command state machine: resets, read id start, register slave
//
// Operation
// - synchronous reset command is accepted in every state
// - sync reset records code, clears flags, resets every lun, invalidates pages
// - lun reset records code, clears status and column flags, awaits address
// - store each lun reset address cycle, start once all have arrived
// - lun reset requests only the addressed lun and drives busy low
// - lun reset done goes idle, or read idle when status flag set
// - reset perform runs target actions, busy low, records resume state
// - read status command during sync reset goes to status execution
// - read with status flag set during sync reset enters status read, the next read returns status
// - resets complete drive ready high, then idle or read idle
// - read id records code, awaits address, clears column flags, invalidates pages
// - address 00h selects id path, 20h signature path, command redecodes
// - id path returns maker byte then device byte, then read idle
// - signature path returns one byte per read, read idle after fourth
`timescale 1ns/1ps
`default_nettype none

module nand_target_reset_readid_fsm #(
  parameter int NUM_LUNS = 4,
  // arbitrary identity values, replaced by software through the registers
  parameter logic [7:0] MFR_ID_DEFAULT = 8'hA5,
  parameter logic [7:0] DEV_ID_DEFAULT = 8'h5A
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic cmdStrobe,
  input wire logic addrStrobe,
  input wire logic readStrobe,
  input wire logic [7:0] ioIn,
  output logic [7:0] ioOut,
  output logic ioOe,
  output logic readyBusy,
  output logic [NUM_LUNS-1:0] lunResetReq,
  output logic lunInvalidate,
  input wire logic [NUM_LUNS-1:0] lunResetDone
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (NUM_LUNS < 1 || NUM_LUNS > nand_target_pkg::MAX_LUNS) begin : g_chk
    $error("NUM_LUNS must lie between 1 and 8");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  nand_target_pkg::core_t core_reg;
  nand_target_pkg::core_t core_next;

  logic cmdEvent;
  logic addrEvent;
  logic readEvent;
  logic [7:0] busByte;
  logic [nand_target_pkg::MAX_LUNS-1:0] lunDoneWide;
  logic allLunsDone;
  logic targetTimeDone;
  logic [2:0] addrNeeded;
  logic busValid;

  // absent luns count as finished so a stray address cannot hang a reset
  genvar gi;
  for (gi = 0; gi < nand_target_pkg::MAX_LUNS; gi++) begin : g_done
    if (gi < NUM_LUNS) begin : g_real
      assign lunDoneWide[gi] = lunResetDone[gi];
    end else begin : g_pad
      assign lunDoneWide[gi] = 1'b1;
    end
  end

  // edges are taken from the second stage against a third, never the first
  assign cmdEvent = core_reg.pinSync.cmd & ~core_reg.pinPrev.cmd;
  assign addrEvent = core_reg.pinSync.addr & ~core_reg.pinPrev.addr;
  assign readEvent = core_reg.pinSync.rd & ~core_reg.pinPrev.rd;
  assign busByte = core_reg.pinSync.io;
  assign allLunsDone = &lunDoneWide;
  assign targetTimeDone =
    (core_reg.waitCnt >= nand_target_pkg::TGT_RST_CYCLES);
  // zero cycles would pass the count check on the first address anyway, treat it as one
  assign addrNeeded = (core_reg.addrCycles == 3'h0) ? 3'h1
                                                    : core_reg.addrCycles;
  assign busValid = (haddr[31:8] == 24'h00_0000);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic nand_target_pkg::state_t decodeCmd(
    input logic [7:0] code
  );
    if (code == nand_target_pkg::CMD_READ_ID) begin
      return nand_target_pkg::ST_RID_EXEC;
    end else if (code == nand_target_pkg::CMD_READ_STATUS) begin
      return nand_target_pkg::ST_RS_EXEC;
    end else begin
      return nand_target_pkg::ST_IDLE;
    end
  endfunction

  function automatic logic [7:0] statusByte(input logic rb);
    logic [7:0] s;
    s = 8'h00;
    s[nand_target_pkg::STATUS_BYTE_RDY_BIT] = rb;
    s[nand_target_pkg::STATUS_BYTE_ARDY_BIT] = rb;
    return s;
  endfunction

  function automatic logic [31:0] readReg(
    input nand_target_pkg::core_t c,
    input logic [7:0] a
  );
    logic [31:0] d;
    d = 32'h0000_0000;
    if (a == nand_target_pkg::REG_STATUS) begin
      d[15:0] = c.state;
      d[nand_target_pkg::STAT_RB_BIT] = c.readyBusy;
      d[nand_target_pkg::STAT_STATUS_OUT_BIT] = c.statusOutputFlag;
      d[nand_target_pkg::STAT_CHG_COL_BIT] = c.columnChangeAllowed;
      d[nand_target_pkg::STAT_CHG_COL_ENH_BIT] =
        c.enhancedColumnChangeAllowed;
    end else if (a == nand_target_pkg::REG_LAST_CMD) begin
      d[7:0] = c.lastCommandCode;
    end else if (a == nand_target_pkg::REG_CONFIG) begin
      d[2:0] = c.addrCycles;
    end else if (a == nand_target_pkg::REG_ID_BYTES) begin
      d[7:0] = c.mfrId;
      d[15:8] = c.devId;
    end else if (a == nand_target_pkg::REG_SIGNATURE) begin
      d = c.sigWord;
    end
    return d;
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    core_next = core_reg;

    // pins come from the host's domain, two flops before use
    core_next.pinMeta.cmd = cmdStrobe;
    core_next.pinMeta.addr = addrStrobe;
    core_next.pinMeta.rd = readStrobe;
    core_next.pinMeta.io = ioIn;
    core_next.pinSync = core_reg.pinMeta;
    core_next.pinPrev = core_reg.pinSync;

    core_next.lunReq = '0;
    core_next.lunInval = 1'b0;
    core_next.ioOe = 1'b0;

    // -- register bus: zero wait states, always okay
    core_next.hreadyout = 1'b1;
    if (core_reg.wrPend) begin
      if (core_reg.wrAddr == nand_target_pkg::REG_CONFIG) begin
        core_next.addrCycles = hwdata[2:0];
      end else if (core_reg.wrAddr == nand_target_pkg::REG_ID_BYTES) begin
        core_next.mfrId = hwdata[7:0];
        core_next.devId = hwdata[15:8];
      end else if (core_reg.wrAddr == nand_target_pkg::REG_SIGNATURE) begin
        core_next.sigWord = hwdata;
      end
      core_next.wrPend = 1'b0;
    end
    if (hsel && htrans[1] && hready) begin
      if (hwrite) begin
        core_next.wrPend = busValid;
        core_next.wrAddr = haddr[7:0];
        core_next.hrdata = 32'h0000_0000;
      end else if (busValid) begin
        core_next.hrdata = readReg(core_reg, haddr[7:0]);
      end else begin
        core_next.hrdata = 32'h0000_0000;
      end
    end

    // -- command state machine
    case (core_reg.state)
      nand_target_pkg::ST_IDLE: begin
        if (cmdEvent) begin
          core_next.state = decodeCmd(busByte);
          core_next.resumeState = nand_target_pkg::ST_IDLE;
        end
      end
      nand_target_pkg::ST_IDLE_RD: begin
        // bytes past the end of a sequence are indeterminate, zero here
        if (readEvent) begin
          core_next.ioOut = 8'h00;
          core_next.ioOe = 1'b1;
        end
        if (cmdEvent) begin
          core_next.state = decodeCmd(busByte);
          core_next.resumeState = nand_target_pkg::ST_IDLE;
        end
      end
      nand_target_pkg::ST_IDLE_RD_STATUS: begin
        if (readEvent) begin
          core_next.ioOut = statusByte(core_reg.readyBusy);
          core_next.ioOe = 1'b1;
          core_next.state = core_reg.resumeState;
        end
      end
      nand_target_pkg::ST_RS_EXEC: begin
        core_next.statusOutputFlag = 1'b1;
        core_next.state = core_reg.resumeState;
      end
      nand_target_pkg::ST_RST_SYNC: begin
        core_next.lastCommandCode = nand_target_pkg::CMD_SYNC_RESET;
        core_next.statusOutputFlag = 1'b0;
        core_next.lunReq = '1;
        core_next.columnChangeAllowed = 1'b0;
        core_next.enhancedColumnChangeAllowed = 1'b0;
        core_next.lunInval = 1'b1;
        core_next.waitCnt = '0;
        core_next.state = nand_target_pkg::ST_RST_PERFORM;
      end
      nand_target_pkg::ST_RST_PERFORM: begin
        core_next.readyBusy = 1'b0;
        core_next.resumeState = nand_target_pkg::ST_RST_PERFORM;
        if (!targetTimeDone) begin
          core_next.waitCnt = core_reg.waitCnt + 1'b1;
        end
        // a status read must not abort the reset, it resumes here
        if (cmdEvent && busByte == nand_target_pkg::CMD_READ_STATUS) begin
          core_next.state = nand_target_pkg::ST_RS_EXEC;
        end else if (targetTimeDone && allLunsDone) begin
          core_next.state = nand_target_pkg::ST_RST_END;
        end else if (readEvent && core_reg.statusOutputFlag) begin
          core_next.state = nand_target_pkg::ST_IDLE_RD_STATUS;
        end
      end
      nand_target_pkg::ST_RST_END: begin
        core_next.readyBusy = 1'b1;
        if (core_reg.statusOutputFlag) begin
          core_next.state = nand_target_pkg::ST_IDLE_RD;
        end else begin
          core_next.state = nand_target_pkg::ST_IDLE;
        end
      end
      nand_target_pkg::ST_RST_LUN_EXEC: begin
        core_next.lastCommandCode = nand_target_pkg::CMD_LUN_RESET;
        core_next.statusOutputFlag = 1'b0;
        core_next.columnChangeAllowed = 1'b0;
        core_next.enhancedColumnChangeAllowed = 1'b0;
        core_next.addrCnt = 3'h0;
        core_next.state = nand_target_pkg::ST_RST_LUN_ADDR;
      end
      nand_target_pkg::ST_RST_LUN_ADDR: begin
        // the lun number rides in the last, most significant cycle
        if (addrEvent) begin
          core_next.lunSel = busByte[nand_target_pkg::LUN_SEL_W-1:0];
          core_next.addrCnt = core_reg.addrCnt + 1'b1;
          if (core_reg.addrCnt + 3'h1 >= addrNeeded) begin
            core_next.lunReq[busByte[nand_target_pkg::LUN_SEL_W-1:0]] =
              1'b1;
            core_next.waitCnt = '0;
            core_next.state = nand_target_pkg::ST_RST_LUN_PERFORM;
          end
        end else if (cmdEvent) begin
          core_next.state = decodeCmd(busByte);
          core_next.resumeState = nand_target_pkg::ST_IDLE;
        end
      end
      nand_target_pkg::ST_RST_LUN_PERFORM: begin
        core_next.readyBusy = 1'b0;
        if (!targetTimeDone) begin
          core_next.waitCnt = core_reg.waitCnt + 1'b1;
        end
        if (targetTimeDone && lunDoneWide[core_reg.lunSel]) begin
          core_next.readyBusy = 1'b1;
          if (core_reg.statusOutputFlag) begin
            core_next.state = nand_target_pkg::ST_IDLE_RD;
          end else begin
            core_next.state = nand_target_pkg::ST_IDLE;
          end
        end
      end
      nand_target_pkg::ST_RID_EXEC: begin
        core_next.lastCommandCode = nand_target_pkg::CMD_READ_ID;
        core_next.columnChangeAllowed = 1'b0;
        core_next.enhancedColumnChangeAllowed = 1'b0;
        core_next.sigIdx = 2'h0;
        if (addrEvent) begin
          if (busByte == nand_target_pkg::ADDR_ID_CODE) begin
            core_next.state = nand_target_pkg::ST_RID_ADDR_ID;
          end else if (busByte == nand_target_pkg::ADDR_SIGNATURE) begin
            core_next.state = nand_target_pkg::ST_RID_ADDR_SIG;
          end else begin
            core_next.state = nand_target_pkg::ST_IDLE;
          end
        end else if (cmdEvent) begin
          core_next.state = decodeCmd(busByte);
          core_next.resumeState = nand_target_pkg::ST_IDLE;
        end
      end
      nand_target_pkg::ST_RID_ADDR_ID: begin
        if (readEvent) begin
          core_next.ioOut = core_reg.mfrId;
          core_next.ioOe = 1'b1;
          core_next.state = nand_target_pkg::ST_RID_MFR;
        end else if (cmdEvent) begin
          core_next.state = decodeCmd(busByte);
          core_next.resumeState = nand_target_pkg::ST_IDLE;
        end
      end
      nand_target_pkg::ST_RID_MFR: begin
        if (readEvent) begin
          core_next.ioOut = core_reg.devId;
          core_next.ioOe = 1'b1;
          core_next.state = nand_target_pkg::ST_RID_DEV;
        end else if (cmdEvent) begin
          core_next.state = decodeCmd(busByte);
          core_next.resumeState = nand_target_pkg::ST_IDLE;
        end
      end
      nand_target_pkg::ST_RID_DEV: begin
        core_next.state = nand_target_pkg::ST_IDLE_RD;
      end
      nand_target_pkg::ST_RID_ADDR_SIG: begin
        if (readEvent) begin
          core_next.ioOut = core_reg.sigWord[core_reg.sigIdx * 8 +: 8];
          core_next.ioOe = 1'b1;
          core_next.state = nand_target_pkg::ST_RID_SIG;
        end else if (cmdEvent) begin
          core_next.state = decodeCmd(busByte);
          core_next.resumeState = nand_target_pkg::ST_IDLE;
        end
      end
      nand_target_pkg::ST_RID_SIG: begin
        if (core_reg.sigIdx == nand_target_pkg::SIG_LAST_IDX) begin
          core_next.state = nand_target_pkg::ST_IDLE_RD;
        end else begin
          core_next.sigIdx = core_reg.sigIdx + 2'h1;
          core_next.state = nand_target_pkg::ST_RID_ADDR_SIG;
        end
      end
      default: begin
        core_next.state = nand_target_pkg::ST_IDLE;
      end
    endcase

    // both resets win over anything a state decided this cycle
    if (cmdEvent && busByte == nand_target_pkg::CMD_SYNC_RESET) begin
      core_next.state = nand_target_pkg::ST_RST_SYNC;
    end else if (cmdEvent && busByte == nand_target_pkg::CMD_LUN_RESET) begin
      core_next.state = nand_target_pkg::ST_RST_LUN_EXEC;
    end
    // every accepted read id invalidates, a repeated one too
    if (cmdEvent && core_next.state == nand_target_pkg::ST_RID_EXEC) begin
      core_next.lunInval = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      core_reg <= '0;
      core_reg.state <= nand_target_pkg::ST_IDLE;
      core_reg.resumeState <= nand_target_pkg::ST_IDLE;
      core_reg.lastCommandCode <= nand_target_pkg::LAST_CMD_RESET;
      core_reg.readyBusy <= 1'b1;
      core_reg.hreadyout <= 1'b1;
      core_reg.addrCycles <= nand_target_pkg::CFG_ADDR_CYC_RESET;
      core_reg.mfrId <= MFR_ID_DEFAULT;
      core_reg.devId <= DEV_ID_DEFAULT;
      core_reg.sigWord <= nand_target_pkg::SIGNATURE_RESET;
    end else if (ce) begin
      core_reg <= core_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs, straight from flops except hresp, tied low
  // ----------------------------------------------------------------
  assign hreadyout = core_reg.hreadyout;
  assign hrdata = core_reg.hrdata;
  assign hresp = 1'b0;
  assign ioOut = core_reg.ioOut;
  assign ioOe = core_reg.ioOe;
  assign readyBusy = core_reg.readyBusy;
  assign lunResetReq = core_reg.lunReq[NUM_LUNS-1:0];
  assign lunInvalidate = core_reg.lunInval;

endmodule

`default_nettype wire

// ===== tb/nand_fsm_sva.sv
// checker: timing relations at the target pins
`timescale 1ns/1ps
`default_nettype none
module nand_fsm_sva #(
  parameter int NUM_LUNS = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cmdStrobe,
  input wire logic [7:0] ioIn,
  input wire logic readyBusy,
  input wire logic [NUM_LUNS-1:0] lunResetReq,
  input wire logic lunInvalidate,
  input wire logic [NUM_LUNS-1:0] lunResetDone,
  input wire logic ioOe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ----
  // command sequences
  // ----
  sequence s_cmd(logic [7:0] c);
    $rose(cmdStrobe) && ioIn == c;
  endsequence
  sequence s_busyStart;
    $fell(readyBusy);
  endsequence
  property p_sync;
    s_cmd(8'hFC) |-> ##[1:8] (&lunResetReq && lunInvalidate);
  endproperty
  property p_rid;
    s_cmd(8'h90) |-> ##[1:8] lunInvalidate;
  endproperty
  property p_busy;
    |lunResetReq |-> ##[1:2] !readyBusy;
  endproperty
  property p_pulse;
    |lunResetReq |=> lunResetReq == '0;
  endproperty
  property p_ioOe;
    ioOe |=> !ioOe;
  endproperty
  property p_rbRose;
    $rose(readyBusy) |-> &$past(lunResetDone);
  endproperty
  property p_rbLow;
    s_busyStart |-> !readyBusy [*3];
  endproperty
  property p_rbEnd;
    s_busyStart |-> ##[1:600] readyBusy;
  endproperty
  a_sync: assert property (p_sync) else $error("no sync request");
  a_rid: assert property (p_rid) else $error("no invalidate");
  a_busy: assert property (p_busy) else $error("busy not low");
  a_pulse: assert property (p_pulse) else $error("long request");
  a_ioOe: assert property (p_ioOe) else $error("long ioOe");
  a_rbRose: assert property (p_rbRose) else $error("early ready");
  a_rbLow: assert property (p_rbLow) else $error("short busy");
  a_rbEnd: assert property (p_rbEnd) else $error("busy stuck");
endmodule
`default_nettype wire

// ===== tb/nand_host_model.sv
// host model: command, address and read cycles on the pin link
`timescale 1ns/1ps
`default_nettype none
module nand_host_model (
  input wire logic clk,
  input wire logic [7:0] ioOut,
  input wire logic ioOe,
  output logic cmdStrobe,
  output logic addrStrobe,
  output logic readStrobe,
  output logic [7:0] ioIn
);
  logic [7:0] rdByte = 8'h00;
  initial begin
    cmdStrobe = 1'b0;
    addrStrobe = 1'b0;
    readStrobe = 1'b0;
    ioIn = 8'h00;
  end
  always @(posedge clk) begin
    if (ioOe === 1'b1) rdByte <= ioOut;
  end
  // kind 0 command, 1 address, 2 read request
  task automatic cycle(input int kind, input logic [7:0] b);
    @(posedge clk);
    ioIn <= b;
    @(posedge clk);
    cmdStrobe <= (kind == 0);
    addrStrobe <= (kind == 1);
    readStrobe <= (kind == 2);
    repeat (3) @(posedge clk);
    {cmdStrobe, addrStrobe, readStrobe} <= 3'h0;
    // released bus shows the inverse so a held value cannot pass
    ioIn <= ~b;
    repeat (4) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
// testbench: register bus and pin scenarios for the target fsm
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk;
  logic rst_n;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [31:0] hwdata;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic [31:0] r;
  logic cmdStrobe, addrStrobe, readStrobe, ioOe, readyBusy, lunInvalidate;
  logic [7:0] ioIn, ioOut;
  logic [3:0] lunResetReq;
  logic [3:0] lunResetDone = 4'hF;
  logic [3:0] lastReq = 4'h0;
  int lunCnt [4] = '{default: 0};
  int lunDelay = 6;
  int cyc = 0;
  int err_total = 0;
  int n_checks = 0;
  nand_target_reset_readid_fsm u_dut (
    .clk(clk), .rst_n(rst_n), .ce(1'b1), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .cmdStrobe(cmdStrobe), .addrStrobe(addrStrobe),
    .readStrobe(readStrobe), .ioIn(ioIn), .ioOut(ioOut), .ioOe(ioOe),
    .readyBusy(readyBusy), .lunResetReq(lunResetReq),
    .lunInvalidate(lunInvalidate), .lunResetDone(lunResetDone));
  nand_host_model u_host (.clk(clk), .ioOut(ioOut), .ioOe(ioOe),
    .cmdStrobe(cmdStrobe), .addrStrobe(addrStrobe),
    .readStrobe(readStrobe), .ioIn(ioIn));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // ----
  // lun side: done drops on request, returns lunDelay cycles later
  // ----
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (|lunResetReq) lastReq <= lunResetReq;
    for (int i = 0; i < 4; i++) begin
      lunResetDone[i] <= !lunResetReq[i] && lunCnt[i] <= 1;
      if (lunResetReq[i]) lunCnt[i] <= lunDelay;
      else if (lunCnt[i] > 0) lunCnt[i] <= lunCnt[i] - 1;
    end
    if (cyc == 20000) begin
      err_total++;
      $display("MISMATCH at %0t: timeout", $time);
      complete_run();
    end
  end
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    r = hrdata;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0);
    chk(r, exp);
    chk({31'h0, hresp}, 32'h0);
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    rst_n = 1'b0;
    hsel = 1'b1;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rd(8'h00, 32'h0001_0001);
    rd(8'h04, 32'h0000_00FF);
    rd(8'h08, 32'h0000_0003);
    rd(8'h0C, 32'h0000_5AA5);
    ahb(1'b1, 8'h04, 32'h0000_0012);
    rd(8'h04, 32'h0000_00FF);
    rd(8'h40, 32'h0);
    $display("test registers done");
    // sync reset cuts into a read id wait
    u_host.cycle(0, 8'h90);
    u_host.cycle(0, 8'hFC);
    while (readyBusy !== 1'b1) @(posedge clk);
    chk({28'h0, lastReq}, 32'hF);
    rd(8'h04, 32'h0000_00FC);
    rd(8'h00, 32'h0001_0001);
    $display("test sync reset done");
    ahb(1'b1, 8'h0C, 32'h0000_3CC3);
    ahb(1'b1, 8'h10, 32'h4433_2211);
    u_host.cycle(0, 8'h90);
    rd(8'h04, 32'h0000_0090);
    u_host.cycle(1, 8'h00);
    u_host.cycle(2, 8'h00);
    chk({24'h0, u_host.rdByte}, 32'hC3);
    u_host.cycle(2, 8'h00);
    chk({24'h0, u_host.rdByte}, 32'h3C);
    rd(8'h00, 32'h0001_0002);
    u_host.cycle(0, 8'h90);
    u_host.cycle(1, 8'h20);
    for (int i = 0; i < 4; i++) begin
      u_host.cycle(2, 8'h00);
      chk({24'h0, u_host.rdByte}, (32'h4433_2211 >> (8 * i)) & 32'hFF);
    end
    rd(8'h00, 32'h0001_0002);
    $display("test read id done");
    // two address cycles; only the last one picks the lun
    ahb(1'b1, 8'h08, 32'h0000_0002);
    u_host.cycle(0, 8'h90);
    u_host.cycle(0, 8'hFA);
    rd(8'h04, 32'h0000_00FA);
    u_host.cycle(1, 8'h05);
    rd(8'h00, 32'h0001_0040);
    u_host.cycle(1, 8'h02);
    while (readyBusy !== 1'b1) @(posedge clk);
    chk({28'h0, lastReq}, 32'h4);
    rd(8'h00, 32'h0001_0001);
    $display("test lun reset done");
    lunDelay = 200;
    u_host.cycle(0, 8'hFC);
    u_host.cycle(0, 8'h70);
    rd(8'h00, 32'h0002_0100);
    // last reply was 44h, so a missing status byte still shows bit 6
    u_host.cycle(2, 8'h00);
    u_host.cycle(2, 8'h00);
    chk({24'h0, u_host.rdByte & 8'h60}, 32'h0);
    while (readyBusy !== 1'b1) @(posedge clk);
    rd(8'h00, 32'h0003_0002);
    $display("test status in reset done");
    complete_run();
  end
endmodule
bind nand_target_reset_readid_fsm nand_fsm_sva #(.NUM_LUNS(NUM_LUNS)) u_sva (
  .clk(clk), .rst_n(rst_n), .cmdStrobe(cmdStrobe), .ioIn(ioIn),
  .readyBusy(readyBusy), .lunResetReq(lunResetReq),
  .lunInvalidate(lunInvalidate), .lunResetDone(lunResetDone), .ioOe(ioOe));
`default_nettype wire
